// ===== scim_mapper.sv
// Servo control input mapper with Avalon-MM register slave
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module scim_mapper #(
	parameter int CLR_W1_CYC = scim_pkg::CLR_W1_CYC,
	parameter int CLR_W2_CYC = scim_pkg::CLR_W2_CYC,
	parameter int CLR_W3_CYC = scim_pkg::CLR_W3_CYC,
	parameter int CLR_W4_CYC = scim_pkg::CLR_W4_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [scim_pkg::NUM_LINES-1:0] line_connected,
	output logic servo_energise,
	output logic pos_inhibit,
	output logic neg_inhibit,
	output logic [1:0] overtravel_action,
	output logic counter_clear,
	output logic alloc_error
);
	localparam int N = scim_pkg::NUM_LINES;

	logic [3:0] line_func [N];
	logic line_nc [N];
	logic [4:1] line_hit [N];
	logic [N-1:0] line_misplaced;
	logic [1:0] overtravel_setup_param;
	logic [2:0] error_reset_mode_param;
	logic servo_fn, pos_fn, neg_fn, clr_on;
	logic [scim_pkg::CNT_W-1:0] width_cnt, need_cyc;
	logic qualified, qualified_d, level_mode, edge_mode;
	logic next_clear;
	logic access;
	logic [3:0] line_idx;
	logic line_sel;
	logic [31:0] next_readdata;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_line
			scim_line_map #(.LINE_INDEX(g)) u_map (
				.connected(line_connected[g]),
				.func(line_func[g]),
				.normally_closed(line_nc[g]),
				.hit(line_hit[g]),
				.misplaced(line_misplaced[g])
			);
		end
	endgenerate

	always_comb begin
		servo_fn = 1'b0;
		pos_fn = 1'b0;
		neg_fn = 1'b0;
		clr_on = 1'b0;
		for (int i = 0; i < N; i++) begin
			servo_fn = servo_fn | line_hit[i][1];
			pos_fn = pos_fn | line_hit[i][2];
			neg_fn = neg_fn | line_hit[i][3];
			clr_on = clr_on | line_hit[i][4];
		end
	end

	// Bus slave: one wait cycle, then the access completes
	assign access = (read || write) && !waitrequest;
	assign line_idx = address[5:2];
	assign line_sel = (address[7:6] == 2'b00) && (line_idx < 4'(N)) && (address[1:0] == 2'b00);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= !((read || write) && waitrequest);
		end
	end

	always_comb begin
		next_readdata = 32'h0000_0000;
		if (line_sel) begin
			next_readdata[scim_pkg::LCFG_FUNC_LSB +: 4] = line_func[line_idx];
			next_readdata[scim_pkg::LCFG_NC_BIT] = line_nc[line_idx];
		end else if (address == scim_pkg::OFS_CTRL) begin
			next_readdata[scim_pkg::CTRL_OT_LSB +: 2] = overtravel_setup_param;
			next_readdata[scim_pkg::CTRL_MODE_LSB +: 3] = error_reset_mode_param;
		end else if (address == scim_pkg::OFS_STATUS) begin
			next_readdata[5:0] = {clr_on, alloc_error, counter_clear, neg_inhibit,
				pos_inhibit, servo_energise};
		end else if (address == scim_pkg::OFS_RAW) begin
			next_readdata[N-1:0] = line_connected;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			readdata <= 32'h0000_0000;
		end else if (read && waitrequest) begin
			readdata <= next_readdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < N; i++) begin
				line_func[i] <= scim_pkg::LCFG_RST[i][3:0];
				line_nc[i] <= scim_pkg::LCFG_RST[i][4];
			end
		end else if (access && write && line_sel && byteenable[0]) begin
			line_func[line_idx] <= writedata[scim_pkg::LCFG_FUNC_LSB +: 4];
			line_nc[line_idx] <= writedata[scim_pkg::LCFG_NC_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			overtravel_setup_param <= scim_pkg::OT_RST;
			error_reset_mode_param <= scim_pkg::MODE_RST;
		end else if (access && write && address == scim_pkg::OFS_CTRL && byteenable[0]) begin
			overtravel_setup_param <= writedata[scim_pkg::CTRL_OT_LSB +: 2];
			error_reset_mode_param <= writedata[scim_pkg::CTRL_MODE_LSB +: 3];
		end
	end

	// Drive outputs
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			servo_energise <= 1'b0;
			pos_inhibit <= 1'b0;
			neg_inhibit <= 1'b0;
			overtravel_action <= 2'h0;
			alloc_error <= 1'b0;
		end else begin
			servo_energise <= servo_fn;
			// Setting 1 leaves limit inputs without effect
			pos_inhibit <= pos_fn && (overtravel_setup_param != scim_pkg::OT_DISABLED);
			neg_inhibit <= neg_fn && (overtravel_setup_param != scim_pkg::OT_DISABLED);
			overtravel_action <= overtravel_setup_param;
			alloc_error <= |line_misplaced;
		end
	end

	// Reset input must stand for the mode's least width before it acts
	always_comb begin
		level_mode = 1'b0;
		edge_mode = 1'b0;
		case (error_reset_mode_param)
			3'h1: begin
				need_cyc = scim_pkg::CNT_W'(CLR_W1_CYC);
				level_mode = 1'b1;
			end
			3'h2: begin
				need_cyc = scim_pkg::CNT_W'(CLR_W2_CYC);
				level_mode = 1'b1;
			end
			3'h3: begin
				need_cyc = scim_pkg::CNT_W'(CLR_W3_CYC);
				edge_mode = 1'b1;
			end
			3'h4: begin
				need_cyc = scim_pkg::CNT_W'(CLR_W4_CYC);
				edge_mode = 1'b1;
			end
			default: begin
				need_cyc = scim_pkg::CNT_W'(CLR_W1_CYC);
			end
		endcase
	end

	assign qualified = clr_on && (width_cnt >= need_cyc);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			width_cnt <= '0;
		end else if (!clr_on) begin
			width_cnt <= '0;
		end else if (width_cnt < need_cyc) begin
			width_cnt <= width_cnt + 1'b1;
		end
	end

	always_comb begin
		next_clear = 1'b0;
		if (level_mode) begin
			next_clear = qualified;
		end else if (edge_mode) begin
			next_clear = qualified && !qualified_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			qualified_d <= 1'b0;
			counter_clear <= 1'b0;
		end else begin
			qualified_d <= qualified;
			counter_clear <= next_clear;
		end
	end

	sequence s_clr_off2;
		!clr_on ##1 1'b1;
	endsequence

	sequence s_pulse_then_low;
		counter_clear ##1 !counter_clear;
	endsequence

	servo_follow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		servo_energise == $past(servo_fn)) else $error("servo output does not follow enable");
	pos_inhibit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		pos_fn && overtravel_setup_param != 2'h1 |=> pos_inhibit)
		else $error("positive limit not applied");
	neg_inhibit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		neg_fn && overtravel_setup_param != 2'h1 |=> neg_inhibit)
		else $error("negative limit not applied");
	ot_disabled_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		overtravel_setup_param == 2'h1 |=> !pos_inhibit && !neg_inhibit)
		else $error("limit acted while disabled");
	clr_level_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		level_mode && qualified |=> counter_clear) else $error("level clear not held");
	clr_once_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		edge_mode && $stable(error_reset_mode_param) && counter_clear
		|-> s_pulse_then_low) else $error("edge clear lasted more than a cycle");
	clr_release_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_clr_off2 |=> !counter_clear) else $error("clear without reset input");
	alloc_error_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(|line_misplaced) |=> alloc_error) else $error("misplaced reset not flagged");
	default_map_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(rstn) |-> line_func[5] == 4'h1) else $error("servo enable not on line six");
	bus_wait_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!waitrequest |=> waitrequest) else $error("waitrequest low for two cycles");
endmodule : scim_mapper
`default_nettype wire

// ===== scim_pkg.sv
// Constants shared by the servo control input mapper
//
// Function
// - Normally open input: function OFF when open, ON when tied to return terminal.
// - Normally closed input: function ON when open, OFF when tied to return terminal.
// - Servo enable is mapped by default onto input line six in every mode.
// - Servo loop is energised while servo enable is ON, de-energised while OFF.
// - Positive limit ON applies the chosen over-travel reaction to positive motion.
// - Negative limit ON applies the chosen over-travel reaction to negative motion.
// - Position error reset clears deviation counter, by default on its rising edge.
// - Modes 1 and 2 hold counter cleared while ON; modes 3, 4 clear once per edge.
// - Error reset only works on line seven; any other allocation raises an error.
package scim_pkg;
	localparam int NUM_LINES = 10;
	localparam int FUNC_W = 4;
	// Function codes
	localparam logic [3:0] FN_NONE = 4'h0;
	localparam logic [3:0] FN_SERVO = 4'h1;
	localparam logic [3:0] FN_POS_LIM = 4'h2;
	localparam logic [3:0] FN_NEG_LIM = 4'h3;
	localparam logic [3:0] FN_ERR_RST = 4'h4;
	// Line that alone may carry the error reset function (line seven)
	localparam int ERR_RST_LINE = 6;
	// Register byte offsets
	localparam logic [7:0] OFS_LINE_BASE = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h40;
	localparam logic [7:0] OFS_STATUS = 8'h44;
	localparam logic [7:0] OFS_RAW = 8'h48;
	// Line config fields
	localparam int LCFG_FUNC_LSB = 0;
	localparam int LCFG_NC_BIT = 4;
	// Control fields
	localparam int CTRL_OT_LSB = 0;
	localparam int CTRL_MODE_LSB = 4;
	// Reset values of line configs: line one..ten
	localparam logic [4:0] LCFG_RST [NUM_LINES] = '{
		5'h13, 5'h12, 5'h00, 5'h00, 5'h00, 5'h01, 5'h04, 5'h00, 5'h00, 5'h00};
	localparam logic [1:0] OT_RST = 2'h0;
	localparam logic [2:0] MODE_RST = 3'h3;
	localparam logic [1:0] OT_DISABLED = 2'h1;
	// Least widths of the reset signal per mode, in microseconds
	localparam int CLK_MHZ = 200;
	localparam int CLR_W1_US = 500;
	localparam int CLR_W2_US = 1000;
	localparam int CLR_W3_US = 100;
	localparam int CLR_W4_US = 1000;
	localparam int CLR_W1_CYC = CLR_W1_US * CLK_MHZ;
	localparam int CLR_W2_CYC = CLR_W2_US * CLK_MHZ;
	localparam int CLR_W3_CYC = CLR_W3_US * CLK_MHZ;
	localparam int CLR_W4_CYC = CLR_W4_US * CLK_MHZ;
	localparam int CNT_W = 18;
endpackage : scim_pkg

// ===== scim_line_map.sv
// One input line: polarity and function decode
`timescale 1ns/1ps
`default_nettype none
module scim_line_map #(
	parameter int LINE_INDEX = 0
) (
	input wire logic connected,
	input wire logic [3:0] func,
	input wire logic normally_closed,
	output logic [4:1] hit,
	output logic misplaced
);
	logic on;

	assign on = connected ^ normally_closed;

	// Unassigned lines leave every hit low
	always_comb begin
		hit[1] = on && (func == scim_pkg::FN_SERVO);
		hit[2] = on && (func == scim_pkg::FN_POS_LIM);
		hit[3] = on && (func == scim_pkg::FN_NEG_LIM);
		// Error reset on a foreign line is refused outright
		hit[4] = on && (func == scim_pkg::FN_ERR_RST)
			&& (LINE_INDEX == scim_pkg::ERR_RST_LINE);
		misplaced = (func == scim_pkg::FN_ERR_RST)
			&& (LINE_INDEX != scim_pkg::ERR_RST_LINE);
	end
endmodule : scim_line_map
`default_nettype wire

// ===== scim_host_model.sv
// Host controller model driving the isolated control input contacts
`timescale 1ns/1ps
`default_nettype none
module scim_host_model (
	input wire logic sys_clk,
	input wire logic [9:0] contact_req,
	output logic [9:0] line_connected
);
	// Contacts move only just after an edge, as a host output register would
	// Limit contacts are wired to open past the limit, servo enable closes to run
	always_ff @(posedge sys_clk) begin
		line_connected <= contact_req;
	end
endmodule : scim_host_model
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the servo control input mapper
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic [9:0] contact_req = 10'h000;
	logic [9:0] line_connected;
	logic servo_energise, pos_inhibit, neg_inhibit, counter_clear, alloc_error;
	logic [1:0] overtravel_action;
	logic [31:0] rd;
	int mismatches = 0;
	int checks_done = 0;
	always #2.5 sys_clk = ~sys_clk;
	// Short clear widths keep the run brief
	scim_mapper #(.CLR_W1_CYC(4), .CLR_W2_CYC(8), .CLR_W3_CYC(2), .CLR_W4_CYC(8)) dut (
		.sys_clk(sys_clk), .rstn(rstn), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .line_connected(line_connected),
		.servo_energise(servo_energise), .pos_inhibit(pos_inhibit),
		.neg_inhibit(neg_inhibit), .overtravel_action(overtravel_action),
		.counter_clear(counter_clear), .alloc_error(alloc_error));
	scim_host_model host (.sys_clk(sys_clk), .contact_req(contact_req),
		.line_connected(line_connected));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		$display("mismatches %0d checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	// One Avalon access; held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		address <= a;
		writedata <= d;
		byteenable <= 4'hf;
		read <= !wr;
		write <= wr;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 50) begin
			mismatches++;
			end_sim();
		end
	endtask : bus
	task automatic lines(input logic [9:0] v);
		@(posedge sys_clk);
		contact_req <= v;
		repeat (4) @(posedge sys_clk);
	endtask : lines
	task automatic outs(input logic [2:0] exp);
		check(32'({servo_energise, pos_inhibit, neg_inhibit}), 32'(exp));
	endtask : outs
	initial begin
		int n;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		bus(1'b0, 8'h00, 32'h0);
		check(rd, 32'h13);
		bus(1'b0, 8'h14, 32'h0);
		check(rd, 32'h01);
		bus(1'b0, 8'h18, 32'h0);
		check(rd, 32'h04);
		bus(1'b0, 8'h40, 32'h0);
		check(rd, 32'h30);
		bus(1'b0, 8'h80, 32'h0);
		check(rd, 32'h0);
		// All open: servo off, closed-type limits read ON
		lines(10'h000);
		outs(3'b011);
		check(32'(overtravel_action), 32'h0);
		lines(10'h023);
		outs(3'b100);
		// Unassigned lines toggled must change nothing
		lines(10'h3bf);
		outs(3'b100);
		check(32'(counter_clear), 32'h0);
		bus(1'b0, 8'h48, 32'h0);
		check(rd, 32'h3bf);
		bus(1'b1, 8'h40, 32'h31);
		lines(10'h020);
		outs(3'b100);
		check(32'(overtravel_action), 32'h1);
		bus(1'b1, 8'h40, 32'h32);
		repeat (3) @(posedge sys_clk);
		outs(3'b111);
		check(32'(overtravel_action), 32'h2);
		for (int m = 1; m <= 4; m++) begin
			bus(1'b1, 8'h40, 32'(m * 16 + 2));
			lines(10'h060);
			n = 0;
			while (counter_clear !== 1'b1 && n < 40) begin
				@(posedge sys_clk);
				n++;
			end
			check(32'(n < 40), 32'h1);
			repeat (3) @(posedge sys_clk);
			check(32'(counter_clear), 32'(m < 3));
			lines(10'h020);
			repeat (2) @(posedge sys_clk);
			check(32'(counter_clear), 32'h0);
		end
		// Error reset also given to line three, line seven keeps it: flagged and ignored
		bus(1'b1, 8'h08, 32'h04);
		lines(10'h024);
		check(32'(alloc_error), 32'h1);
		repeat (20) @(posedge sys_clk);
		check(32'(counter_clear), 32'h0);
		bus(1'b1, 8'h08, 32'h00);
		repeat (3) @(posedge sys_clk);
		check(32'(alloc_error), 32'h0);
		end_sim();
	end
endmodule : testbench
`default_nettype wire
